// file: dcw_pkg.sv
// Operation
// R1: code_protect_n low blocks external flash access.
// R2: boot_flash_write_allow low blocks boot flash writes.
// R3: programmer writes word zero reserved bits correctly.
// R4: watchdog_force_on high runs watchdog, ignores disable.
// R5: watchdog_force_on low: watchdog off, software enables.
// R6: postscale field gives divide ratio two^code.
// R7: postscale codes above 10100 act as 10100.
// R8: monitor field 1x disables switching and monitor.
// R9: field 01 switching only; 00 both enabled.
// R10: programmer writes word one reserved bits high.
// R11: fields set by programming only, software reads.
// R12: words latched after reset, held until reset.
`default_nettype none
package dcw_pkg;

  // wishbone byte offsets
  localparam logic [7:0] ADR_CFG0 = 8'h00;
  localparam logic [7:0] ADR_CFG1 = 8'h04;
  localparam logic [7:0] ADR_CTRL = 8'h08;
  localparam logic [7:0] ADR_STAT = 8'h0c;

  // erased nonvolatile cells read as ones
  localparam logic [31:0] CFG_ERASED = 32'hffff_ffff;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // config_word_zero fields
  localparam int CFG0_PROTECT_BIT = 28;
  localparam int CFG0_BOOT_WR_BIT = 24;
  localparam logic [31:0] CFG0_RSVD_MASK = 32'hfef0_0000;
  localparam logic [31:0] CFG0_RSVD_VAL = 32'h6ef0_0000;

  // config_word_one fields
  localparam int CFG1_DOG_FORCE_BIT = 23;
  localparam int CFG1_POSTSCALE_LSB = 16;
  localparam int CFG1_CLK_MON_LSB = 14;
  localparam logic [31:0] CFG1_RSVD_MASK = 32'hff60_0000;
  localparam logic [31:0] CFG1_RSVD_VAL = 32'hff60_0000;

  localparam logic [4:0] POSTSCALE_MAX = 5'h14;

  // control register
  localparam int CTRL_DOG_SW_EN_BIT = 0;

  // status register
  localparam int STAT_DONE_BIT = 0;
  localparam int STAT_DOG_RUN_BIT = 1;
  localparam int STAT_CLK_SW_BIT = 2;
  localparam int STAT_FAIL_SAFE_BIT = 3;
  localparam int STAT_BOOT_WR_BIT = 4;
  localparam int STAT_PROG_ACC_BIT = 5;
  localparam int STAT_RSVD_OK_BIT = 6;
  localparam int STAT_POSTSCALE_LSB = 8;

  typedef enum logic [1:0] {LOAD_RD0, LOAD_RD1, LOAD_CAP1, LOAD_DONE} dcw_load_state_type;

  // clamp of the postscale code
  function automatic logic [4:0] dcw_postscale_exp(input logic [4:0] code);
    dcw_postscale_exp = (code > POSTSCALE_MAX) ? POSTSCALE_MAX : code;
  endfunction

endpackage
`default_nettype wire

// file: dcw_nv_store.sv
`timescale 1ns/10ps
`default_nettype none
module dcw_nv_store #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 2,
  parameter int AW = 1
) (
  input wire logic clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic wr_en, // programmer write strobe
  input wire logic [AW-1:0] wr_addr, // programmer word select
  input wire logic [WIDTH-1:0] wr_data, // programmer write data
  input wire logic [AW-1:0] rd_addr, // read word select
  output logic [WIDTH-1:0] rd_data // registered read data
);

  // array is not reset: contents survive every reset like flash cells
  logic [WIDTH-1:0] mem [DEPTH] = '{default: dcw_pkg::CFG_ERASED};
  logic [WIDTH-1:0] next_rd_data;

  always_comb begin
    next_rd_data = mem[rd_addr];
  end

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_data <= '0;
    end else begin
      rd_data <= next_rd_data;
    end
  end

endmodule
`default_nettype wire

// file: dcw_config_decode.sv
`timescale 1ns/10ps
`default_nettype none
module dcw_config_decode (
  input wire logic clk, // system clock
  input wire logic rst_b, // synchronous reset, active low
  input wire logic wb_cyc_i, // wishbone cycle
  input wire logic wb_stb_i, // wishbone strobe
  input wire logic wb_we_i, // wishbone write enable
  input wire logic [7:0] wb_adr_i, // wishbone byte address
  input wire logic [3:0] wb_sel_i, // wishbone byte lanes
  input wire logic [31:0] wb_dat_i, // wishbone write data
  output logic [31:0] wb_dat_o, // wishbone read data
  output logic wb_ack_o, // wishbone acknowledge
  input wire logic prog_wr_en, // programmer writes a word
  input wire logic prog_wr_sel, // programmer word select
  input wire logic [31:0] prog_wr_data, // programmer word value
  output logic config_loaded, // words latched after reset
  output logic prog_access_allow, // external flash access allowed
  output logic boot_flash_write_allow, // code may write boot flash
  output logic watchdog_timer_run, // watchdog runs
  output logic [4:0] watchdog_postscale_exp, // effective postscale code
  output logic [20:0] watchdog_divide_ratio, // postscale divide ratio
  output logic clock_switch_en, // clock switching allowed
  output logic fail_safe_monitor_en, // fail-safe monitor on
  output logic config_reserved_ok // reserved bits as expected
);

  dcw_pkg::dcw_load_state_type state, next_state;
  logic [31:0] config_word_zero, next_config_word_zero;
  logic [31:0] config_word_one, next_config_word_one;
  logic [31:0] control, next_control;
  logic [31:0] nv_rd_data;
  logic nv_rd_addr;
  logic next_config_loaded;
  logic next_prog_access_allow;
  logic next_boot_flash_write_allow;
  logic next_watchdog_timer_run;
  logic [4:0] next_watchdog_postscale_exp;
  logic [20:0] next_watchdog_divide_ratio;
  logic next_clock_switch_en;
  logic next_fail_safe_monitor_en;
  logic next_config_reserved_ok;
  logic [31:0] next_wb_dat_o;
  logic next_wb_ack_o;
  logic bus_hit;
  logic done;
  logic [31:0] status;
  logic [4:0] ps_code;
  logic [1:0] cksm;

  // programmer is the only writer of the stored words
  dcw_nv_store #(
    .WIDTH(32),
    .DEPTH(2),
    .AW(1)
  ) u_store (
    .clk(clk),
    .rst_b(rst_b),
    .wr_en(prog_wr_en),
    .wr_addr(prog_wr_sel),
    .wr_data(prog_wr_data),
    .rd_addr(nv_rd_addr),
    .rd_data(nv_rd_data)
  );

  assign done = (state == dcw_pkg::LOAD_DONE);
  assign ps_code = config_word_one[dcw_pkg::CFG1_POSTSCALE_LSB +: 5];
  assign cksm = config_word_one[dcw_pkg::CFG1_CLK_MON_LSB +: 2];

  // loader: three cycles after reset release, then frozen
  always_comb begin
    next_state = state;
    next_config_word_zero = config_word_zero;
    next_config_word_one = config_word_one;
    nv_rd_addr = 1'b0;
    unique case (state)
      dcw_pkg::LOAD_RD0: begin
        next_state = dcw_pkg::LOAD_RD1;
      end
      dcw_pkg::LOAD_RD1: begin
        nv_rd_addr = 1'b1;
        next_config_word_zero = nv_rd_data; // R12
        next_state = dcw_pkg::LOAD_CAP1;
      end
      dcw_pkg::LOAD_CAP1: begin
        nv_rd_addr = 1'b1;
        next_config_word_one = nv_rd_data; // R12
        next_state = dcw_pkg::LOAD_DONE;
      end
      dcw_pkg::LOAD_DONE: begin
        next_state = dcw_pkg::LOAD_DONE;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      state <= dcw_pkg::LOAD_RD0;
      config_word_zero <= dcw_pkg::CFG_ERASED;
      config_word_one <= dcw_pkg::CFG_ERASED;
    end else begin
      state <= next_state;
      config_word_zero <= next_config_word_zero;
      config_word_one <= next_config_word_one;
    end
  end

  // decode; while loading everything sits in its safe off state
  always_comb begin
    next_config_loaded = done;
    next_prog_access_allow = 1'b0;
    next_boot_flash_write_allow = 1'b0;
    next_watchdog_timer_run = 1'b0;
    next_watchdog_postscale_exp = dcw_pkg::POSTSCALE_MAX;
    next_watchdog_divide_ratio = 21'(1) << dcw_pkg::POSTSCALE_MAX;
    next_clock_switch_en = 1'b0;
    next_fail_safe_monitor_en = 1'b0;
    next_config_reserved_ok = 1'b0;
    if (done) begin
      next_prog_access_allow = config_word_zero[dcw_pkg::CFG0_PROTECT_BIT]; // R1
      next_boot_flash_write_allow = config_word_zero[dcw_pkg::CFG0_BOOT_WR_BIT]; // R2
      // software bit cannot stop a forced watchdog
      next_watchdog_timer_run = config_word_one[dcw_pkg::CFG1_DOG_FORCE_BIT] | // R4
        control[dcw_pkg::CTRL_DOG_SW_EN_BIT]; // R5
      next_watchdog_postscale_exp = dcw_pkg::dcw_postscale_exp(ps_code); // R7
      next_watchdog_divide_ratio = 21'(1) << dcw_pkg::dcw_postscale_exp(ps_code); // R6
      next_clock_switch_en = !cksm[1]; // R8 R9
      next_fail_safe_monitor_en = (cksm == 2'b00); // R8 R9
      // a word left half programmed shows up here rather than silently
      next_config_reserved_ok =
        ((config_word_zero & dcw_pkg::CFG0_RSVD_MASK) == dcw_pkg::CFG0_RSVD_VAL) && // R3
        ((config_word_one & dcw_pkg::CFG1_RSVD_MASK) == dcw_pkg::CFG1_RSVD_VAL); // R10
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      config_loaded <= 1'b0;
      prog_access_allow <= 1'b0;
      boot_flash_write_allow <= 1'b0;
      watchdog_timer_run <= 1'b0;
      watchdog_postscale_exp <= dcw_pkg::POSTSCALE_MAX;
      watchdog_divide_ratio <= 21'(1) << dcw_pkg::POSTSCALE_MAX;
      clock_switch_en <= 1'b0;
      fail_safe_monitor_en <= 1'b0;
      config_reserved_ok <= 1'b0;
    end else begin
      config_loaded <= next_config_loaded;
      prog_access_allow <= next_prog_access_allow;
      boot_flash_write_allow <= next_boot_flash_write_allow;
      watchdog_timer_run <= next_watchdog_timer_run;
      watchdog_postscale_exp <= next_watchdog_postscale_exp;
      watchdog_divide_ratio <= next_watchdog_divide_ratio;
      clock_switch_en <= next_clock_switch_en;
      fail_safe_monitor_en <= next_fail_safe_monitor_en;
      config_reserved_ok <= next_config_reserved_ok;
    end
  end

  always_comb begin
    status = '0;
    status[dcw_pkg::STAT_DONE_BIT] = config_loaded;
    status[dcw_pkg::STAT_DOG_RUN_BIT] = watchdog_timer_run;
    status[dcw_pkg::STAT_CLK_SW_BIT] = clock_switch_en;
    status[dcw_pkg::STAT_FAIL_SAFE_BIT] = fail_safe_monitor_en;
    status[dcw_pkg::STAT_BOOT_WR_BIT] = boot_flash_write_allow;
    status[dcw_pkg::STAT_PROG_ACC_BIT] = prog_access_allow;
    status[dcw_pkg::STAT_RSVD_OK_BIT] = config_reserved_ok;
    status[dcw_pkg::STAT_POSTSCALE_LSB +: 5] = watchdog_postscale_exp;
  end

  // bus slave: ack one cycle after the request, held off until loaded
  assign bus_hit = wb_cyc_i && wb_stb_i && !wb_ack_o && done;

  always_comb begin
    next_wb_ack_o = bus_hit;
    next_wb_dat_o = '0;
    next_control = control;
    if (bus_hit && !wb_we_i) begin
      unique case (wb_adr_i)
        dcw_pkg::ADR_CFG0: next_wb_dat_o = config_word_zero; // R11
        dcw_pkg::ADR_CFG1: next_wb_dat_o = config_word_one; // R11
        dcw_pkg::ADR_CTRL: next_wb_dat_o = control;
        dcw_pkg::ADR_STAT: next_wb_dat_o = status;
        default: next_wb_dat_o = '0;
      endcase
    end
    // writes to the config words are acked and dropped
    // a write lands at the edge where the master sees ack, while its request is still held
    if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == dcw_pkg::ADR_CTRL && wb_sel_i[0]) begin // R11
      next_control[dcw_pkg::CTRL_DOG_SW_EN_BIT] = wb_dat_i[dcw_pkg::CTRL_DOG_SW_EN_BIT]; // R5
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
      control <= dcw_pkg::CTRL_RESET;
    end else begin
      wb_ack_o <= next_wb_ack_o;
      wb_dat_o <= next_wb_dat_o;
      control <= next_control;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  property p_code_protect;
    done |=> prog_access_allow == $past(config_word_zero[dcw_pkg::CFG0_PROTECT_BIT]);
  endproperty
  a_code_protect: assert property (p_code_protect) else $error("code protect decode wrong"); // R1

  property p_boot_write;
    done && !config_word_zero[dcw_pkg::CFG0_BOOT_WR_BIT] |=> !boot_flash_write_allow;
  endproperty
  a_boot_write: assert property (p_boot_write) else $error("boot flash write not blocked"); // R2

  property p_boot_write_on;
    done && config_word_zero[dcw_pkg::CFG0_BOOT_WR_BIT] |=> boot_flash_write_allow;
  endproperty
  a_boot_write_on: assert property (p_boot_write_on) else $error("boot flash write not allowed"); // R2

  property p_dog_forced;
    done && config_word_one[dcw_pkg::CFG1_DOG_FORCE_BIT] |=> watchdog_timer_run [*2];
  endproperty
  a_dog_forced: assert property (p_dog_forced) else $error("forced watchdog stopped"); // R4

  property p_dog_soft;
    done && !config_word_one[dcw_pkg::CFG1_DOG_FORCE_BIT]
      |=> watchdog_timer_run == $past(control[dcw_pkg::CTRL_DOG_SW_EN_BIT]);
  endproperty
  a_dog_soft: assert property (p_dog_soft) else $error("software watchdog control wrong"); // R5

  property p_ratio;
    done && ps_code <= dcw_pkg::POSTSCALE_MAX
      |=> watchdog_divide_ratio == (21'(1) << $past(ps_code)) && watchdog_postscale_exp == $past(ps_code);
  endproperty
  a_ratio: assert property (p_ratio) else $error("postscale ratio wrong"); // R6

  property p_ratio_clamp;
    done && ps_code > dcw_pkg::POSTSCALE_MAX
      |=> watchdog_postscale_exp == 5'h14 && watchdog_divide_ratio == 21'h10_0000;
  endproperty
  a_ratio_clamp: assert property (p_ratio_clamp) else $error("postscale not clamped"); // R7

  property p_cksm_off;
    done && cksm[1] |=> !clock_switch_en && !fail_safe_monitor_en;
  endproperty
  a_cksm_off: assert property (p_cksm_off) else $error("clock switching not disabled"); // R8

  property p_cksm_on;
    done && !cksm[1] |=> clock_switch_en && fail_safe_monitor_en == !$past(cksm[0]);
  endproperty
  a_cksm_on: assert property (p_cksm_on) else $error("clock switch mode wrong"); // R9

  property p_sw_read;
    wb_ack_o && !wb_we_i && wb_adr_i == dcw_pkg::ADR_CFG1 |-> wb_dat_o == config_word_one;
  endproperty
  a_sw_read: assert property (p_sw_read) else $error("config word read wrong"); // R11

  property p_load_hold;
    state == dcw_pkg::LOAD_RD0 |-> ##3 done ##1 ($stable(config_word_zero) && $stable(config_word_one)) [*4];
  endproperty
  a_load_hold: assert property (p_load_hold) else $error("config words not latched and held"); // R12

  property p_ratio_match;
    watchdog_divide_ratio == (21'(1) << watchdog_postscale_exp);
  endproperty
  a_ratio_match: assert property (p_ratio_match) else $error("divide ratio and postscale disagree"); // R6

  property p_safe_loading;
    !done |=> !prog_access_allow && !boot_flash_write_allow && !watchdog_timer_run && !clock_switch_en
      && !fail_safe_monitor_en && !config_loaded;
  endproperty
  a_safe_loading: assert property (p_safe_loading) else $error("outputs not safe while loading"); // R12

  property p_words_frozen;
    done |=> $stable(config_word_zero) && $stable(config_word_one);
  endproperty
  a_words_frozen: assert property (p_words_frozen) else $error("config words changed after load"); // R11

  property p_ctrl_write;
    wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_adr_i == dcw_pkg::ADR_CTRL && wb_sel_i[0]
      |=> control[dcw_pkg::CTRL_DOG_SW_EN_BIT] == $past(wb_dat_i[dcw_pkg::CTRL_DOG_SW_EN_BIT]);
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) else $error("software watchdog bit not written"); // R5

  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle"); // R11

  property p_ack_wait;
    wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:5] wb_ack_o;
  endproperty
  a_ack_wait: assert property (p_ack_wait) else $error("request not acknowledged"); // R11

endmodule
`default_nettype wire

// file: dcw_prog_model.sv
`timescale 1ns/10ps
`default_nettype none
module dcw_prog_model (
  input wire logic clk, // system clock
  input wire logic start, // pulse: program both words
  input wire logic fix_rsvd, // 0 leaves reserved bits as given
  input wire logic [31:0] word0, // config_word_zero value
  input wire logic [31:0] word1, // config_word_one value
  output logic prog_wr_en, // write strobe
  output logic prog_wr_sel, // word select
  output logic [31:0] prog_wr_data // word value
);
  logic [1:0] step;
  initial begin
    prog_wr_en = 1'b0;
    prog_wr_sel = 1'b0;
    prog_wr_data = 32'h0;
    step = 2'h0;
  end
  // idle data toggles so a stale word can never pass for a fresh one
  always @(posedge clk) begin
    prog_wr_en <= 1'b0;
    prog_wr_data <= ~prog_wr_data;
    if (step == 2'h1) begin
      prog_wr_en <= 1'b1;
      prog_wr_sel <= 1'b0;
      prog_wr_data <= fix_rsvd ? ((word0 & 32'h7fff_ffff) | 32'h6ef0_0000) : word0;
      step <= 2'h2;
    end else if (step == 2'h2) begin
      prog_wr_en <= 1'b1;
      prog_wr_sel <= 1'b1;
      prog_wr_data <= fix_rsvd ? (word1 | 32'hff60_0000) : word1;
      step <= 2'h0;
    end
    if (start) begin
      step <= 2'h1;
    end
  end
endmodule
`default_nettype wire

// file: dcw_config_decode_tb.sv
`timescale 1ns/10ps
`default_nettype none
module dcw_config_decode_tb;
  logic clk, rst_b, cyc, stb, we, start, fix, ack, en, wsel, loaded, pacc, bwr, run, csw, fsm, rok;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] dat, q, w0, w1, p0, p1, dat_o, pdat;
  logic [4:0] pexp;
  logic [20:0] ratio;
  int err_total, tests_run, i;
  logic [31:0] t0 [5] = '{32'h0, 32'h1100_0000, 32'h1000_0000, 32'h0100_0000, 32'h0};
  logic [31:0] t1 [5] = '{32'h0, 32'h0094_4000, 32'h0015_8000, 32'h001f_c000, 32'h000a_0000};
  logic [4:0] tf = 5'b01111;

  dcw_config_decode uut (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .prog_wr_en(en), .prog_wr_sel(wsel), .prog_wr_data(pdat), .config_loaded(loaded),
    .prog_access_allow(pacc), .boot_flash_write_allow(bwr), .watchdog_timer_run(run),
    .watchdog_postscale_exp(pexp), .watchdog_divide_ratio(ratio), .clock_switch_en(csw),
    .fail_safe_monitor_en(fsm), .config_reserved_ok(rok));
  dcw_prog_model prog (.clk(clk), .start(start), .fix_rsvd(fix), .word0(w0), .word1(w1),
    .prog_wr_en(en), .prog_wr_sel(wsel), .prog_wr_data(pdat));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task end_sim;
    if (err_total == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  // one classic cycle; ack and read data are taken at the rising edge that samples ack high
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = dat_o;
    if (ack !== 1'b1) begin
      err_total++;
      $display("unexpected at %0t: no ack", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  task rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'h0);
    chk(q, e);
  endtask

  function automatic logic [31:0] st(input logic [31:0] a, input logic [31:0] b, input logic sw);
    logic [31:0] s;
    s = 32'h1;
    s[1] = b[23] | sw;
    s[2] = ~b[15];
    s[3] = b[15:14] == 2'b00;
    s[4] = a[24];
    s[5] = a[28];
    s[6] = ((a & 32'hfef0_0000) == 32'h6ef0_0000) && ((b & 32'hff60_0000) == 32'hff60_0000);
    s[12:8] = (b[20:16] > 5'h14) ? 5'h14 : b[20:16];
    return s;
  endfunction

  task reload(input int cyc_n);
    int n;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (cyc_n) @(posedge clk);
    @(negedge clk);
    chk({31'h0, loaded}, 32'h0);
    @(posedge clk);
    rst_b <= 1'b1;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (loaded !== 1'b1 && n < 20);
  endtask

  task check_all(input logic [31:0] a, input logic [31:0] b);
    logic [31:0] s;
    s = st(a, b, 1'b0);
    rd(8'h00, a);
    rd(8'h04, b);
    rd(8'h0c, s);
    chk({26'h0, pacc, bwr, run, csw, fsm, rok}, {26'h0, s[5], s[4], s[1], s[2], s[3], s[6]});
    chk({27'h0, pexp}, {27'h0, s[12:8]});
    chk({11'h0, ratio}, 32'h1 << s[12:8]);
    xfer(1'b1, 8'h00, ~a, 4'hf);
    rd(8'h00, a);
    rd(8'h10, 32'h0);
    xfer(1'b1, 8'h08, 32'h1, 4'h1);
    rd(8'h08, 32'h1);
    xfer(1'b1, 8'h08, 32'h0, 4'he);
    rd(8'h0c, st(a, b, 1'b1));
    xfer(1'b1, 8'h08, 32'h0, 4'h1);
    rd(8'h0c, s);
  endtask

  initial begin
    err_total = 0;
    tests_run = 0;
    {rst_b, cyc, stb, we, start, fix, adr, sel, dat, w0, w1} = '0;
    p0 = 32'hffff_ffff;
    p1 = p0;
    reload(6);
    check_all(p0, p1);
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      w0 <= t0[i];
      w1 <= t1[i];
      fix <= tf[i];
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      repeat (4) @(posedge clk);
      rd(8'h0c, st(p0, p1, 1'b0));
      p0 = tf[i] ? ((t0[i] & 32'h7fff_ffff) | 32'h6ef0_0000) : t0[i];
      p1 = tf[i] ? (t1[i] | 32'hff60_0000) : t1[i];
      reload(2);
      check_all(p0, p1);
    end
    end_sim;
  end

  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    $display("unexpected at %0t: timeout", $time);
    end_sim;
  end
endmodule
`default_nettype wire
